/* hw/emd_decoder.v */
// Byte-stream decoder of the extended move instruction group.
//
// Notes on behaviour
// - Compatibility mode needs escape prefix, one byte longer.
// - Short direct byte move touching ports 0-3 adds one state.
// - Load byte register from short direct, 2 states.
// - Load word register from short direct, 3 states.
// - Store word register to long direct, 4 states.
// - Store byte register to short direct, 3 states.
// - Store dword register to short direct, 6 states.
// - Store word register to short direct, 4 states.
// - Store dword register to long direct, 6 states.
// - Load byte via dword plus offset, 6 states.
// - Load word via dword plus offset, 7 states.
// - Store byte via word plus offset, 5 states.
// - Store byte via dword plus offset, 6 states.
`timescale 1ns/100ps
`include "emd_defines.vh"
module emd_decoder (
  input  wire        core_clk_i,
  input  wire        rst_i,
  input  wire        compat_mode_i,
  input  wire        byte_valid_i,
  input  wire [7:0]  byte_i,
  output wire        byte_ready_o,
  output reg         dec_valid_o,
  output reg         dec_miss_o,
  output reg         dec_illegal_o,
  output reg  [2:0]  amode_o,
  output reg         store_o,
  output reg  [3:0]  data_reg_o,
  output reg  [1:0]  data_size_o,
  output reg  [3:0]  ptr_reg_o,
  output reg  [1:0]  ptr_size_o,
  output reg  [15:0] address_o,
  output reg  [15:0] word_offset_o,
  output reg  [31:0] immediate_o,
  output reg         io_port_o,
  output reg  [2:0]  length_o,
  output reg  [3:0]  states_o
);
  reg  [1:0] state_q;
  reg  [1:0] state_d;
  reg  [2:0] cnt_q;
  reg  [7:0] buf_q [0:4];
  wire [7:0] cur [0:4];
  wire       cls_hit;
  wire [2:0] cls_len;
  wire [3:0] cls_st;
  wire [2:0] cls_am;
  wire [1:0] cls_dsz;
  wire [1:0] cls_psz;
  wire       cls_store;
  wire       take;
  wire       grp_now;
  wire       last;
  wire       port_hit;
  wire       io_extra;

  // Opcodes that open this group; anything else is left to other decoders.
  function grp_op;
    input [7:0] op;
    begin
      case (op)
        `EMD_OP_LOAD_EXT, `EMD_OP_STORE_EXT, `EMD_OP_LOAD_IND, `EMD_OP_STORE_IND,
        `EMD_OP_LD_B_WD, `EMD_OP_LD_W_WD, `EMD_OP_LD_B_DD, `EMD_OP_LD_W_DD,
        `EMD_OP_ST_B_WD, `EMD_OP_ST_W_WD, `EMD_OP_ST_B_DD: grp_op = 1'b1;
        default: grp_op = 1'b0;
      endcase
    end
  endfunction

  // The decoder never stalls the fetch path; every offered byte is consumed.
  assign byte_ready_o = 1'b1;
  assign take         = byte_valid_i;
  assign grp_now      = grp_op(byte_i);

  // View of the instruction bytes with the incoming byte placed at its slot.
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_cur
      localparam [2:0] IDX = gi;
      assign cur[gi] = (cnt_q == IDX) ? byte_i : buf_q[gi];
    end
  endgenerate

  emd_classify u_classify (
    .opcode_i    (cur[0]),
    .operand_i   (cur[1]),
    .hit_o       (cls_hit),
    .length_o    (cls_len),
    .states_o    (cls_st),
    .amode_o     (cls_am),
    .data_size_o (cls_dsz),
    .ptr_size_o  (cls_psz),
    .store_o     (cls_store)
  );

  // Count of bytes after any prefix reaches the native length on the final byte.
  assign last = (state_q == `EMD_ST_BODY) && (cnt_q != 3'h1) && (cnt_q + 3'h1 == cls_len);

  assign port_hit = (cur[2] == `EMD_IO_PORT0_ADDR) || (cur[2] == `EMD_IO_PORT1_ADDR) ||
                    (cur[2] == `EMD_IO_PORT2_ADDR) || (cur[2] == `EMD_IO_PORT3_ADDR);
  assign io_extra = (cls_am == `EMD_AM_SHORT_DIRECT_ADDRESS) && (cls_dsz == `EMD_SZ_BYTE) && port_hit;

  always @* begin
    state_d = state_q;
    case (state_q)
      `EMD_ST_IDLE: begin
        if (take) begin
          if (compat_mode_i) begin
            if (byte_i == `EMD_ESC_PREFIX) begin
              state_d = `EMD_ST_PREFIX;
            end
          end else if (grp_now) begin
            state_d = `EMD_ST_BODY;
          end
        end
      end
      `EMD_ST_PREFIX: begin
        if (take) begin
          state_d = grp_now ? `EMD_ST_BODY : `EMD_ST_IDLE;
        end
      end
      `EMD_ST_BODY: begin
        if (take && (((cnt_q == 3'h1) && !cls_hit) || last)) begin
          state_d = `EMD_ST_IDLE;
        end
      end
      default: state_d = `EMD_ST_IDLE;
    endcase
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      state_q <= `EMD_ST_IDLE;
      cnt_q   <= 3'h0;
    end else begin
      state_q <= state_d;
      if (take) begin
        if (state_d == `EMD_ST_BODY) begin
          buf_q[cnt_q] <= byte_i;
          cnt_q        <= cnt_q + 3'h1;
        end else begin
          cnt_q <= 3'h0;
        end
      end
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      dec_valid_o   <= 1'b0;
      dec_miss_o    <= 1'b0;
      dec_illegal_o <= 1'b0;
      amode_o       <= `EMD_AM_NONE;
      store_o       <= 1'b0;
      data_reg_o    <= 4'h0;
      data_size_o   <= `EMD_SZ_BYTE;
      ptr_reg_o     <= 4'h0;
      ptr_size_o    <= `EMD_SZ_BYTE;
      address_o     <= 16'h0000;
      word_offset_o <= 16'h0000;
      immediate_o   <= 32'h00000000;
      io_port_o     <= 1'b0;
      length_o      <= 3'h0;
      states_o      <= 4'h0;
    end else begin
      // In compatibility mode a bare opcode byte is not ours, even if it matches.
      dec_miss_o <= take && (((state_q == `EMD_ST_IDLE) &&
                    (compat_mode_i ? (byte_i != `EMD_ESC_PREFIX) : !grp_now)) ||
                    ((state_q == `EMD_ST_PREFIX) && !grp_now));
      dec_illegal_o <= take && (state_q == `EMD_ST_BODY) && (cnt_q == 3'h1) && !cls_hit;
      dec_valid_o   <= take && last;
      if (take && last) begin
        amode_o     <= cls_am;
        store_o     <= cls_store;
        data_size_o <= cls_dsz;
        ptr_size_o  <= cls_psz;
        io_port_o   <= io_extra;
        length_o    <= cls_len + {2'h0, compat_mode_i};
        states_o    <= cls_st + {3'h0, compat_mode_i} + {3'h0, io_extra};
        case (cls_am)
          `EMD_AM_IND: begin
            ptr_reg_o  <= cur[1][7:4];
            data_reg_o <= cur[2][7:4];
          end
          `EMD_AM_DISP: begin
            // Loads carry the data register first, stores the pointer register first.
            ptr_reg_o  <= cls_store ? cur[1][7:4] : cur[1][3:0];
            data_reg_o <= cls_store ? cur[1][3:0] : cur[1][7:4];
          end
          default: begin
            ptr_reg_o  <= 4'h0;
            data_reg_o <= cur[1][7:4];
          end
        endcase
        case (cls_am)
          `EMD_AM_SHORT_DIRECT_ADDRESS:  address_o <= {8'h00, cur[2]};
          `EMD_AM_LONG_DIRECT_ADDRESS: address_o <= {cur[2], cur[3]};
          default:       address_o <= 16'h0000;
        endcase
        word_offset_o <= (cls_am == `EMD_AM_DISP) ? {cur[2], cur[3]} : 16'h0000;
        case (cls_am)
          `EMD_AM_IMM0: immediate_o <= {16'h0000, cur[2], cur[3]};
          `EMD_AM_IMM1: immediate_o <= {16'hFFFF, cur[2], cur[3]};
          default:      immediate_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // emd_decoder

/* hw/emd_defines.vh */
// Constants shared by the extended move decoder files.
`ifndef EMD_DEFINES_VH
`define EMD_DEFINES_VH

// Escape prefix that opens this group in compatibility opcode mode.
`define EMD_ESC_PREFIX    8'hA5

// Opcode bytes of the group.
`define EMD_OP_LOAD_EXT   8'h7E
`define EMD_OP_STORE_EXT  8'h7A
`define EMD_OP_LOAD_IND   8'h0B
`define EMD_OP_STORE_IND  8'h1B
`define EMD_OP_LD_B_WD    8'h09
`define EMD_OP_LD_W_WD    8'h49
`define EMD_OP_LD_B_DD    8'h29
`define EMD_OP_LD_W_DD    8'h69
`define EMD_OP_ST_B_WD    8'h19
`define EMD_OP_ST_W_WD    8'h59
`define EMD_OP_ST_B_DD    8'h39

// Addressing modes reported on amode_o.
`define EMD_AM_NONE       3'h0
`define EMD_AM_IMM0       3'h1
`define EMD_AM_IMM1       3'h2
`define EMD_AM_SHORT_DIRECT_ADDRESS       3'h3
`define EMD_AM_LONG_DIRECT_ADDRESS      3'h4
`define EMD_AM_IND        3'h5
`define EMD_AM_DISP       3'h6

// Operand sizes of a register field.
`define EMD_SZ_BYTE       2'h0
`define EMD_SZ_WORD       2'h1
`define EMD_SZ_DWORD      2'h2

// Short direct addresses of the four I/O ports.
`define EMD_IO_PORT0_ADDR 8'h80
`define EMD_IO_PORT1_ADDR 8'h90
`define EMD_IO_PORT2_ADDR 8'hA0
`define EMD_IO_PORT3_ADDR 8'hB0

// Decoder sequencer states.
`define EMD_ST_IDLE       2'h0
`define EMD_ST_PREFIX     2'h1
`define EMD_ST_BODY       2'h2

`endif

/* hw/emd_classify.v */
// Opcode and operand-byte classifier of the extended move group.
`timescale 1ns/100ps
`include "emd_defines.vh"
module emd_classify (
  input  wire [7:0] opcode_i,
  input  wire [7:0] operand_i,
  output reg        hit_o,
  output reg  [2:0] length_o,
  output reg  [3:0] states_o,
  output reg  [2:0] amode_o,
  output reg  [1:0] data_size_o,
  output reg  [1:0] ptr_size_o,
  output reg        store_o
);
  // Lengths and state counts are native-mode figures; the top adds the prefix cost.
  always @* begin
    {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} = 16'h0000;
    case (opcode_i)
      `EMD_OP_LOAD_EXT: begin
        case (operand_i[3:0])
          4'h8: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
            {1'b1, 3'h4, 4'h4, `EMD_AM_IMM0, `EMD_SZ_DWORD, `EMD_SZ_BYTE, 1'b0};
          4'hC: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
            {1'b1, 3'h4, 4'h4, `EMD_AM_IMM1, `EMD_SZ_DWORD, `EMD_SZ_BYTE, 1'b0};
          4'h1: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
            {1'b1, 3'h3, 4'h2, `EMD_AM_SHORT_DIRECT_ADDRESS, `EMD_SZ_BYTE, `EMD_SZ_BYTE, 1'b0};
          4'h5: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
            {1'b1, 3'h3, 4'h3, `EMD_AM_SHORT_DIRECT_ADDRESS, `EMD_SZ_WORD, `EMD_SZ_BYTE, 1'b0};
          4'hD: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
            {1'b1, 3'h3, 4'h5, `EMD_AM_SHORT_DIRECT_ADDRESS, `EMD_SZ_DWORD, `EMD_SZ_BYTE, 1'b0};
          4'h3: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
            {1'b1, 3'h4, 4'h2, `EMD_AM_LONG_DIRECT_ADDRESS, `EMD_SZ_BYTE, `EMD_SZ_BYTE, 1'b0};
          4'h7: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
            {1'b1, 3'h4, 4'h3, `EMD_AM_LONG_DIRECT_ADDRESS, `EMD_SZ_WORD, `EMD_SZ_BYTE, 1'b0};
          4'hF: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
            {1'b1, 3'h4, 4'h5, `EMD_AM_LONG_DIRECT_ADDRESS, `EMD_SZ_DWORD, `EMD_SZ_BYTE, 1'b0};
          4'h9: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
            {1'b1, 3'h3, 4'h2, `EMD_AM_IND, `EMD_SZ_BYTE, `EMD_SZ_WORD, 1'b0};
          4'hB: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
            {1'b1, 3'h3, 4'h3, `EMD_AM_IND, `EMD_SZ_BYTE, `EMD_SZ_DWORD, 1'b0};
          default: hit_o = 1'b0;
        endcase
      end
      `EMD_OP_STORE_EXT: begin
        case (operand_i[3:0])
          4'h3: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
            {1'b1, 3'h3, 4'h3, `EMD_AM_SHORT_DIRECT_ADDRESS, `EMD_SZ_BYTE, `EMD_SZ_BYTE, 1'b1};
          4'h5: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
            {1'b1, 3'h3, 4'h4, `EMD_AM_SHORT_DIRECT_ADDRESS, `EMD_SZ_WORD, `EMD_SZ_BYTE, 1'b1};
          4'hD: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
            {1'b1, 3'h3, 4'h6, `EMD_AM_SHORT_DIRECT_ADDRESS, `EMD_SZ_DWORD, `EMD_SZ_BYTE, 1'b1};
          4'h7: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
            {1'b1, 3'h4, 4'h4, `EMD_AM_LONG_DIRECT_ADDRESS, `EMD_SZ_WORD, `EMD_SZ_BYTE, 1'b1};
          4'hF: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
            {1'b1, 3'h4, 4'h6, `EMD_AM_LONG_DIRECT_ADDRESS, `EMD_SZ_DWORD, `EMD_SZ_BYTE, 1'b1};
          4'h9: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
            {1'b1, 3'h3, 4'h3, `EMD_AM_IND, `EMD_SZ_BYTE, `EMD_SZ_WORD, 1'b1};
          4'hB: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
            {1'b1, 3'h3, 4'h4, `EMD_AM_IND, `EMD_SZ_BYTE, `EMD_SZ_DWORD, 1'b1};
          default: hit_o = 1'b0;
        endcase
      end
      `EMD_OP_LOAD_IND, `EMD_OP_STORE_IND: begin
        case (operand_i[3:0])
          4'h8: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
            {1'b1, 3'h3, opcode_i[4] ? 4'h4 : 4'h3, `EMD_AM_IND, `EMD_SZ_WORD,
             `EMD_SZ_WORD, opcode_i[4]};
          4'hA: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
            {1'b1, 3'h3, opcode_i[4] ? 4'h5 : 4'h4, `EMD_AM_IND, `EMD_SZ_WORD,
             `EMD_SZ_DWORD, opcode_i[4]};
          default: hit_o = 1'b0;
        endcase
      end
      `EMD_OP_LD_B_WD: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
        {1'b1, 3'h4, 4'h5, `EMD_AM_DISP, `EMD_SZ_BYTE, `EMD_SZ_WORD, 1'b0};
      `EMD_OP_LD_W_WD: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
        {1'b1, 3'h4, 4'h6, `EMD_AM_DISP, `EMD_SZ_WORD, `EMD_SZ_WORD, 1'b0};
      `EMD_OP_LD_B_DD: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
        {1'b1, 3'h4, 4'h6, `EMD_AM_DISP, `EMD_SZ_BYTE, `EMD_SZ_DWORD, 1'b0};
      `EMD_OP_LD_W_DD: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
        {1'b1, 3'h4, 4'h7, `EMD_AM_DISP, `EMD_SZ_WORD, `EMD_SZ_DWORD, 1'b0};
      `EMD_OP_ST_B_WD: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
        {1'b1, 3'h4, 4'h5, `EMD_AM_DISP, `EMD_SZ_BYTE, `EMD_SZ_WORD, 1'b1};
      `EMD_OP_ST_W_WD: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
        {1'b1, 3'h4, 4'h6, `EMD_AM_DISP, `EMD_SZ_WORD, `EMD_SZ_WORD, 1'b1};
      `EMD_OP_ST_B_DD: {hit_o, length_o, states_o, amode_o, data_size_o, ptr_size_o, store_o} =
        {1'b1, 3'h4, 4'h6, `EMD_AM_DISP, `EMD_SZ_BYTE, `EMD_SZ_DWORD, 1'b1};
      default: hit_o = 1'b0;
    endcase
  end
endmodule // emd_classify

/* test/emd_decoder_asserts.sv */
// Port-level property checker for the extended move decoder.
`timescale 1ns/100ps
module emd_decoder_asserts (
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        compat_mode_i,
  input wire logic        byte_valid_i,
  input wire logic        byte_ready_o,
  input wire logic        dec_valid_o,
  input wire logic        dec_miss_o,
  input wire logic        dec_illegal_o,
  input wire logic [2:0]  amode_o,
  input wire logic        store_o,
  input wire logic [1:0]  data_size_o,
  input wire logic [1:0]  ptr_size_o,
  input wire logic [15:0] address_o,
  input wire logic [31:0] immediate_o,
  input wire logic        io_port_o,
  input wire logic [2:0]  length_o,
  input wire logic [3:0]  states_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // The mode may change right after the final byte, so use the mode of the decoding edge.
  logic      compat_q;
  always @(posedge core_clk_i) compat_q <= compat_mode_i;
  wire [3:0] extra = {3'h0, io_port_o} + {3'h0, compat_q};
  wire       sbyte = dec_valid_o && amode_o == 3'h3 && data_size_o == 2'h0;
  wire       port_hit = address_o == 16'h0080 || address_o == 16'h0090 ||
                        address_o == 16'h00A0 || address_o == 16'h00B0;

  ready_const_a: assert property (byte_ready_o) else $error("ready dropped");
  valid_pulse_a: assert property (dec_valid_o |=> !dec_valid_o) else $error("valid too long");
  one_result_a: assert property (dec_valid_o |-> !dec_miss_o && !dec_illegal_o)
    else $error("two results at once");
  answer_time_a: assert property ((dec_valid_o || dec_miss_o) |-> $past(byte_valid_i))
    else $error("result without a taken byte");
  len_mode_a: assert property (dec_valid_o |-> length_o ==
    ((amode_o == 3'h3 || amode_o == 3'h5) ? 3'h3 : 3'h4) + {2'h0, compat_q})
    else $error("length wrong for mode");
  io_addr_a: assert property (sbyte |-> io_port_o == port_hit)
    else $error("port flag wrong");
  io_only_a: assert property (dec_valid_o && io_port_o |-> sbyte)
    else $error("port flag on other move");
  ld_byte_st_a: assert property (sbyte && !store_o |-> states_o == 4'h2 + extra)
    else $error("byte load states wrong");
  st_byte_st_a: assert property (sbyte && store_o |-> states_o == 4'h3 + extra)
    else $error("byte store states wrong");
  disp_ptr_a: assert property (dec_valid_o && amode_o == 3'h6 |-> ptr_size_o != 2'h0
    && address_o == 16'h0000) else $error("offset form fields wrong");
  imm_high_a: assert property (dec_valid_o && (amode_o == 3'h1 || amode_o == 3'h2) |->
    immediate_o[31:16] == ((amode_o == 3'h2) ? 16'hFFFF : 16'h0000)) else $error("imm high");

  cover property (dec_valid_o && compat_q);
  cover property (dec_valid_o && io_port_o);
  cover property (dec_illegal_o);
  cover property (dec_miss_o && compat_mode_i);
endmodule // emd_decoder_asserts

/* test/tb.sv */
// Self-checking bench for the extended move decoder.
`timescale 1ns/100ps
module tb;
  reg         core_clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         compat_mode_i = 1'b0;
  reg         byte_valid_i = 1'b0;
  reg  [7:0]  byte_i = 8'h00;
  wire        byte_ready_o, dec_valid_o, dec_miss_o, dec_illegal_o, store_o, io_port_o;
  wire [2:0]  amode_o, length_o;
  wire [3:0]  data_reg_o, ptr_reg_o, states_o;
  wire [1:0]  data_size_o, ptr_size_o;
  wire [15:0] address_o, word_offset_o;
  wire [31:0] immediate_o;
  reg  [15:0] rnd = 16'h0021;
  integer     fails = 0;
  integer     n_tests = 0;
  integer     i, k;

  always #5 core_clk_i = ~core_clk_i;

  emd_decoder DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .compat_mode_i(compat_mode_i),
    .byte_valid_i(byte_valid_i), .byte_i(byte_i), .byte_ready_o(byte_ready_o),
    .dec_valid_o(dec_valid_o), .dec_miss_o(dec_miss_o), .dec_illegal_o(dec_illegal_o),
    .amode_o(amode_o), .store_o(store_o), .data_reg_o(data_reg_o), .data_size_o(data_size_o),
    .ptr_reg_o(ptr_reg_o), .ptr_size_o(ptr_size_o), .address_o(address_o),
    .word_offset_o(word_offset_o), .immediate_o(immediate_o), .io_port_o(io_port_o),
    .length_o(length_o), .states_o(states_o));

  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Opcode, nibble, native length, native states, mode, data size, store, pointer size.
  function [26:0] vt(input integer v);
    case (v)
      0: vt = {8'h7E, 4'h1, 3'h3, 4'h2, 3'h3, 2'h0, 1'h0, 2'h0};
      1: vt = {8'h7E, 4'h5, 3'h3, 4'h3, 3'h3, 2'h1, 1'h0, 2'h0};
      2: vt = {8'h7A, 4'h7, 3'h4, 4'h4, 3'h4, 2'h1, 1'h1, 2'h0};
      3: vt = {8'h7A, 4'h3, 3'h3, 4'h3, 3'h3, 2'h0, 1'h1, 2'h0};
      4: vt = {8'h7A, 4'hD, 3'h3, 4'h6, 3'h3, 2'h2, 1'h1, 2'h0};
      5: vt = {8'h7A, 4'h5, 3'h3, 4'h4, 3'h3, 2'h1, 1'h1, 2'h0};
      6: vt = {8'h7A, 4'hF, 3'h4, 4'h6, 3'h4, 2'h2, 1'h1, 2'h0};
      7: vt = {8'h29, 4'h0, 3'h4, 4'h6, 3'h6, 2'h0, 1'h0, 2'h2};
      8: vt = {8'h69, 4'h0, 3'h4, 4'h7, 3'h6, 2'h1, 1'h0, 2'h2};
      9: vt = {8'h19, 4'h0, 3'h4, 4'h5, 3'h6, 2'h0, 1'h1, 2'h1};
      10: vt = {8'h39, 4'h0, 3'h4, 4'h6, 3'h6, 2'h0, 1'h1, 2'h2};
      11: vt = {8'h7E, 4'h8, 3'h4, 4'h4, 3'h1, 2'h2, 1'h0, 2'h0};
      12: vt = {8'h7E, 4'hD, 3'h3, 4'h5, 3'h3, 2'h2, 1'h0, 2'h0};
      13: vt = {8'h7E, 4'h3, 3'h4, 4'h2, 3'h4, 2'h0, 1'h0, 2'h0};
      14: vt = {8'h7E, 4'h7, 3'h4, 4'h3, 3'h4, 2'h1, 1'h0, 2'h0};
      15: vt = {8'h7E, 4'hF, 3'h4, 4'h5, 3'h4, 2'h2, 1'h0, 2'h0};
      16: vt = {8'h09, 4'h0, 3'h4, 4'h5, 3'h6, 2'h0, 1'h0, 2'h1};
      17: vt = {8'h49, 4'h0, 3'h4, 4'h6, 3'h6, 2'h1, 1'h0, 2'h1};
      18: vt = {8'h59, 4'h0, 3'h4, 4'h6, 3'h6, 2'h1, 1'h1, 2'h1};
      19: vt = {8'h7E, 4'h9, 3'h3, 4'h2, 3'h5, 2'h0, 1'h0, 2'h1};
      20: vt = {8'h7E, 4'hB, 3'h3, 4'h3, 3'h5, 2'h0, 1'h0, 2'h2};
      21: vt = {8'h7A, 4'h9, 3'h3, 4'h3, 3'h5, 2'h0, 1'h1, 2'h1};
      22: vt = {8'h7A, 4'hB, 3'h3, 4'h4, 3'h5, 2'h0, 1'h1, 2'h2};
      23: vt = {8'h0B, 4'h8, 3'h3, 4'h3, 3'h5, 2'h1, 1'h0, 2'h1};
      24: vt = {8'h0B, 4'hA, 3'h3, 4'h4, 3'h5, 2'h1, 1'h0, 2'h2};
      25: vt = {8'h1B, 4'h8, 3'h3, 4'h4, 3'h5, 2'h1, 1'h1, 2'h1};
      26: vt = {8'h1B, 4'hA, 3'h3, 4'h5, 3'h5, 2'h1, 1'h1, 2'h2};
      default: vt = {8'h7E, 4'hC, 3'h4, 4'h4, 3'h2, 2'h2, 1'h0, 2'h0};
    endcase
  endfunction

  task chk(input [63:0] name, input [31:0] exp, input [31:0] got);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("BAD %0s exp %h got %h", name, exp, got);
    end
  endtask

  // Bytes stay valid back to back; the decoder never stalls.
  task push(input [7:0] b);
    @(negedge core_clk_i);
    byte_valid_i = 1'b1;
    byte_i = b;
  endtask

  task settle;
    @(posedge core_clk_i);
    #1;
  endtask

  task set_mode(input m);
    @(negedge core_clk_i);
    byte_valid_i = 1'b0;
    compat_mode_i = m;
  endtask

  task run_var(input integer v, input [7:0] a2);
    reg [26:0] t;
    reg [7:0]  b1, b3;
    reg [3:0]  ed, ep;
    reg        io, c, d;
    begin
      t = vt(v);
      rnd = lfsr(rnd);
      b1 = rnd[7:0];
      b3 = rnd[15:8];
      d = t[7:5] == 3'h6;
      c = compat_mode_i;
      if (!d) b1[3:0] = t[18:15];
      if (c) push(8'hA5);
      push(t[26:19]);
      push(b1);
      push(a2);
      if (t[14:12] == 3'h4) push(b3);
      settle;
      io = t[7:5] == 3'h3 && t[4:3] == 2'h0 && a2[3:0] == 4'h0 && a2[7:6] == 2'h2;
      // Indirect forms carry the pointer in the register byte and the data register after it.
      ed = (t[7:5] == 3'h5) ? a2[7:4] : (d && t[2]) ? b1[3:0] : b1[7:4];
      ep = (t[7:5] == 3'h5) ? b1[7:4] : !d ? 4'h0 : t[2] ? b1[7:4] : b1[3:0];
      chk("valid", 1, dec_valid_o);
      chk("length", t[14:12] + c, length_o);
      chk("states", t[11:8] + io + c, states_o);
      chk("amode", t[7:5], amode_o);
      chk("dsize", t[4:3], data_size_o);
      chk("psize", t[1:0], ptr_size_o);
      chk("store", t[2], store_o);
      chk("dreg", ed, data_reg_o);
      chk("preg", ep, ptr_reg_o);
      chk("addr", t[7:5] == 3'h3 ? {8'h00, a2} : t[7:5] == 3'h4 ? {a2, b3} : 0, address_o);
      chk("offset", d ? {a2, b3} : 0, word_offset_o);
      chk("imm", t[7:5] == 3'h1 ? {16'h0000, a2, b3} :
        t[7:5] == 3'h2 ? {16'hFFFF, a2, b3} : 0, immediate_o);
      chk("io", io, io_port_o);
    end
  endtask

  task complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge core_clk_i);
    fails = fails + 1;
    complete_run;
  end

  initial begin
    repeat (10) @(posedge core_clk_i);
    @(negedge core_clk_i);
    rst_i = 1'b0;
    for (k = 0; k < 2; k = k + 1) begin
      set_mode(k[0]);
      for (i = 0; i < 28; i = i + 1) run_var(i, rnd[11:4]);
      for (i = 0; i < 4; i = i + 1) begin
        run_var(0, {i[3:0] + 4'h8, 4'h0});
        run_var(3, {i[3:0] + 4'h8, 4'h0});
      end
      run_var(0, 8'h7F);
      run_var(3, 8'hC0);
    end
    repeat (40) begin
      rnd = lfsr(rnd);
      set_mode(rnd[0]);
      run_var(rnd[14:10] % 28, rnd[15:8]);
    end
    set_mode(1'b0);
    push(8'h00);
    settle;
    chk("miss", 1, dec_miss_o);
    set_mode(1'b1);
    push(8'h7E);
    settle;
    chk("miss", 1, dec_miss_o);
    push(8'hA5);
    push(8'h7E);
    push(8'h06);
    settle;
    chk("illegal", 1, dec_illegal_o);
    chk("valid", 0, dec_valid_o);
    complete_run;
  end
endmodule // tb

bind emd_decoder emd_decoder_asserts u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .compat_mode_i(compat_mode_i), .byte_valid_i(byte_valid_i), .byte_ready_o(byte_ready_o),
  .dec_valid_o(dec_valid_o), .dec_miss_o(dec_miss_o), .dec_illegal_o(dec_illegal_o),
  .amode_o(amode_o), .store_o(store_o), .data_size_o(data_size_o), .ptr_size_o(ptr_size_o),
  .address_o(address_o), .immediate_o(immediate_o), .io_port_o(io_port_o),
  .length_o(length_o), .states_o(states_o));
